/* rtl/completer_request_defines.svh */
// Purpose: Constants for the completer request path
// Assumes: 64-bit datapath, 32-bit Dwords
// Notes: Sideband and descriptor field positions
`ifndef COMPLETER_REQUEST_DEFINES_SVH
`define COMPLETER_REQUEST_DEFINES_SVH
// ----------------------------------------
// Datapath
// ----------------------------------------
`define DATA_W 64
`define KEEP_W 2
`define SIDE_W 17
`define PAY_DW_MAX 8
// ----------------------------------------
// Sideband fields
// ----------------------------------------
`define SB_FIRST_DWORD_BYTE_ENABLES 0
`define SB_LAST_DWORD_BYTE_ENABLES 4
`define SB_BYTE_EN 8
`define SB_SOP 16
// ----------------------------------------
// Descriptor fields
// ----------------------------------------
`define DS_ADDR 2
`define DS_COUNT 64
`define DS_KIND 75
`define DS_TAG 96
`define ALL_BYTES 4'hF
`define NO_BYTES 4'h0
`endif

/* rtl/completer_request_pkg.sv */
// Purpose: Shared types of the completer request path
// Assumes: Constants in completer_request_defines.svh
// Notes: Status codes follow the link protocol
package completer_request_pkg;
	typedef enum logic [1:0] {
		KIND_MEM_RD = 2'h0,
		KIND_IO_WR = 2'h1,
		KIND_IO_RD = 2'h2,
		KIND_ATOMIC = 2'h3
	} req_kind_t;
	typedef enum logic [2:0] {
		STAT_SC = 3'h0,
		STAT_UR = 3'h1,
		STAT_CA = 3'h4
	} cpl_status_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_DESC0 = 2'h1,
		ST_DESC1 = 2'h2,
		ST_PAY = 2'h3
	} beat_state_t;
endpackage

/* rtl/completer_request_if.sv */
// Purpose: Stream link between device end and client end
// Assumes: Both ends on sys_clk
// Notes: No clocking block; ends own the timing
`timescale 1ns/1ps
`default_nettype none
`include "completer_request_defines.svh"
interface completer_request_if;
	logic request_stream_valid;
	logic request_stream_ready;
	logic request_stream_last;
	logic [`DATA_W-1:0] request_stream_data;
	logic [`KEEP_W-1:0] request_stream_keep;
	logic [`SIDE_W-1:0] request_sideband_bus;
	modport device (
		output request_stream_valid,
		input request_stream_ready,
		output request_stream_last,
		output request_stream_data,
		output request_stream_keep,
		output request_sideband_bus
	);
	modport client (
		input request_stream_valid,
		output request_stream_ready,
		input request_stream_last,
		input request_stream_data,
		input request_stream_keep,
		input request_sideband_bus
	);
endinterface
`default_nettype wire

/* rtl/completer_request_device.sv */
// Purpose: Device end, frames requests into stream packets
// Assumes: Source keeps payload dwords 1..8 for atomics
// Notes: 64-bit datapath, descriptor in two beats
`timescale 1ns/1ps
`default_nettype none
`include "completer_request_defines.svh"
module completer_request_device (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Link
	completer_request_if.device link,
	// Request source
	input wire logic reqValid,
	output logic reqReady,
	input wire logic [1:0] reqKind,
	input wire logic [63:0] reqAddr,
	input wire logic [3:0] reqDwords,
	input wire logic [3:0] reqFirstBe,
	input wire logic [3:0] reqLastBe,
	input wire logic [7:0] reqTag,
	input wire logic [255:0] reqPayload,
	input wire logic addrAligned
);
	// ----------------------------------------
	// Byte enable helpers
	// ----------------------------------------
	function automatic logic [3:0] fillUp(input logic [3:0] be);
		fillUp = be[0] ? 4'hF : be[1] ? 4'hE : be[2] ? 4'hC : be[3] ? 4'h8 : 4'h0;
	endfunction
	function automatic logic [3:0] fillDown(input logic [3:0] be);
		fillDown = be[3] ? 4'hF : be[2] ? 4'h7 : be[1] ? 4'h3 : be[0] ? 4'h1 : 4'h0;
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	completer_request_pkg::beat_state_t state_r, state_nxt;
	logic [127:0] desc_r;
	logic [255:0] pay_r;
	logic [3:0] nDw_r;
	logic off_r;
	logic [1:0] kind_r;
	logic [3:0] fbe_r;
	logic [3:0] slot_r, slot_nxt;
	logic [63:0] data_r, data_nxt;
	logic [1:0] keep_r, keep_nxt;
	logic [16:0] side_r, side_nxt;
	logic last_r, last_nxt;
	logic valid_r, valid_nxt;

	// ----------------------------------------
	// Descriptor build
	// ----------------------------------------
	wire logic isIdle = (state_r == completer_request_pkg::ST_IDLE);
	wire logic take = reqValid && isIdle;
	wire logic fire = valid_r && link.request_stream_ready;
	wire logic kMem = (reqKind == completer_request_pkg::KIND_MEM_RD);
	wire logic kIoWr = (reqKind == completer_request_pkg::KIND_IO_WR);
	wire logic kIoRd = (reqKind == completer_request_pkg::KIND_IO_RD);
	wire logic kAtom = (reqKind == completer_request_pkg::KIND_ATOMIC);
	wire logic zeroLen = kMem && (reqDwords == 4'h0);
	// I/O always one dword; zero-length read still counts one
	wire logic [10:0] newCount = (kIoWr || kIoRd || zeroLen) ? 11'h001 : {7'h00, reqDwords};
	wire logic longRead = kMem && (reqDwords > 4'h2);
	wire logic [3:0] newFbe = (kAtom || zeroLen) ? `NO_BYTES : longRead ? fillUp(reqFirstBe) : reqFirstBe;
	wire logic [3:0] newLbe = (kMem && !zeroLen && reqDwords != 4'h1) ? (longRead ? fillDown(reqLastBe) : reqLastBe)
		: `NO_BYTES;
	wire logic [3:0] newN = kIoWr ? 4'h1 : kAtom ? reqDwords : 4'h0;
	wire logic newOff = addrAligned && (kIoWr || kAtom) && reqAddr[2];
	wire logic [61:0] newDwAddr = reqAddr[63:2];
	logic [127:0] newDesc;
	always_comb begin
		newDesc = 128'h0;
		newDesc[`DS_ADDR +: 62] = newDwAddr;
		newDesc[`DS_COUNT +: 11] = newCount;
		newDesc[`DS_KIND +: 2] = reqKind;
		newDesc[`DS_TAG +: 8] = reqTag;
	end
	wire logic [16:0] firstSide = {1'b1, 8'h00, newLbe, newFbe};

	// ----------------------------------------
	// Payload beat lanes
	// ----------------------------------------
	// Slot counts dword positions from the first payload beat
	wire logic [3:0] base = (state_r == completer_request_pkg::ST_DESC1) ? 4'h0 : slot_r;
	wire logic [4:0] endSlot = {1'b0, nDw_r} + {4'h0, off_r};
	wire logic [4:0] base2 = {1'b0, base} + 5'h02;
	wire logic payLast = (base2 >= endSlot);
	wire logic hasPay = (nDw_r != 4'h0);
	logic [63:0] payData;
	logic [1:0] payKeep;
	logic [7:0] payBe;
	genvar j;
	generate
		for (j = 0; j < 2; j++) begin : g_lane
			wire logic [4:0] pos = {1'b0, base} + 5'(j);
			wire logic inRange = (pos >= {4'h0, off_r}) && (pos < endSlot);
			wire logic [2:0] idx = 3'(pos - {4'h0, off_r});
			wire logic [3:0] laneBe = (kind_r == completer_request_pkg::KIND_IO_WR) ? fbe_r : `ALL_BYTES;
			assign payData[j*32 +: 32] = inRange ? pay_r[idx*32 +: 32] : 32'h0;
			assign payKeep[j] = inRange;
			assign payBe[j*4 +: 4] = inRange ? laneBe : `NO_BYTES;
		end
	endgenerate

	// ----------------------------------------
	// Next beat selection
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		slot_nxt = slot_r;
		data_nxt = data_r;
		keep_nxt = keep_r;
		side_nxt = side_r;
		last_nxt = last_r;
		valid_nxt = valid_r;
		unique case (state_r)
			completer_request_pkg::ST_IDLE: begin
				if (take) begin
					state_nxt = completer_request_pkg::ST_DESC0;
					data_nxt = newDesc[63:0];
					keep_nxt = 2'h3;
					side_nxt = firstSide;
					last_nxt = 1'b0;
					valid_nxt = 1'b1;
				end
			end
			completer_request_pkg::ST_DESC0: begin
				if (fire) begin
					state_nxt = completer_request_pkg::ST_DESC1;
					data_nxt = desc_r[127:64];
					keep_nxt = 2'h3;
					side_nxt = 17'h0;
					last_nxt = !hasPay;
				end
			end
			completer_request_pkg::ST_DESC1, completer_request_pkg::ST_PAY: begin
				if (fire && last_r) begin
					state_nxt = completer_request_pkg::ST_IDLE;
					valid_nxt = 1'b0;
					side_nxt = 17'h0;
					last_nxt = 1'b0;
				end else if (fire) begin
					// Payload always opens a fresh beat on this width
					state_nxt = completer_request_pkg::ST_PAY;
					slot_nxt = 4'(base2);
					data_nxt = payData;
					keep_nxt = payKeep;
					side_nxt = {1'b0, payBe, 8'h00};
					last_nxt = payLast;
				end
			end
		endcase
	end

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= completer_request_pkg::ST_IDLE;
			slot_r <= 4'h0;
			data_r <= 64'h0;
			keep_r <= 2'h0;
			side_r <= 17'h0;
			last_r <= 1'b0;
			valid_r <= 1'b0;
		end else begin
			// Only a taken beat moves the bus forward
			state_r <= state_nxt;
			slot_r <= slot_nxt;
			data_r <= data_nxt;
			keep_r <= keep_nxt;
			side_r <= side_nxt;
			last_r <= last_nxt;
			valid_r <= valid_nxt;
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			desc_r <= 128'h0;
			pay_r <= 256'h0;
			nDw_r <= 4'h0;
			off_r <= 1'b0;
			kind_r <= 2'h0;
			fbe_r <= 4'h0;
		end else if (take) begin
			desc_r <= newDesc;
			pay_r <= reqPayload;
			nDw_r <= newN;
			off_r <= newOff;
			kind_r <= reqKind;
			fbe_r <= reqFirstBe;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign reqReady = isIdle;
	assign link.request_stream_valid = valid_r;
	assign link.request_stream_data = data_r;
	assign link.request_stream_keep = keep_r;
	assign link.request_stream_last = last_r;
	assign link.request_sideband_bus = side_r;
endmodule
`default_nettype wire

/* rtl/completer_request_client.sv */
// Purpose: Client end, parses requests and forms completions
// Assumes: Device frames packets as the device end does
// Notes: One completion per request, status from user
`timescale 1ns/1ps
`default_nettype none
`include "completer_request_defines.svh"
module completer_request_client (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Link
	completer_request_if.client link,
	// User side
	input wire logic userReady,
	input wire logic [2:0] answerStatus,
	output logic reqStrobe,
	output logic [1:0] reqKind,
	output logic [63:0] reqByteAddr,
	output logic [12:0] reqByteCount,
	output logic [7:0] reqTag,
	output logic [255:0] reqPayload,
	// Completion request
	output logic cplValid,
	output logic cplWithData,
	output logic [10:0] cplDwords,
	output logic [2:0] cplStatus
);
	// ----------------------------------------
	// Byte enable decode
	// ----------------------------------------
	function automatic logic [1:0] lowOff(input logic [3:0] be);
		lowOff = be[0] ? 2'h0 : be[1] ? 2'h1 : be[2] ? 2'h2 : be[3] ? 2'h3 : 2'h0;
	endfunction
	function automatic logic [1:0] highMiss(input logic [3:0] be);
		highMiss = be[3] ? 2'h0 : be[2] ? 2'h1 : be[1] ? 2'h2 : be[0] ? 2'h3 : 2'h0;
	endfunction

	// ----------------------------------------
	// Capture
	// ----------------------------------------
	logic [63:0] dlo_r;
	logic [3:0] fbe_r, lbe_r;
	logic inDesc1_r;
	logic [3:0] wr_r;
	logic [31:0] pay_r [0:7];
	// Client stretches beats while its user is not ready
	assign link.request_stream_ready = userReady;
	wire logic fire = link.request_stream_valid && userReady;
	wire logic sop = link.request_sideband_bus[`SB_SOP];
	wire logic [63:0] beat = link.request_stream_data;
	wire logic [1:0] kp = link.request_stream_keep;
	wire logic [3:0] wrInc = {3'h0, kp[0]} + {3'h0, kp[1]};
	wire logic [1:0] lastKind = beat[`DS_KIND-64 +: 2];
	wire logic [10:0] count = inDesc1_r ? beat[`DS_COUNT-64 +: 11] : 11'h0;
	wire logic done = fire && link.request_stream_last;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dlo_r <= 64'h0;
			fbe_r <= 4'h0;
			lbe_r <= 4'h0;
			inDesc1_r <= 1'b0;
			wr_r <= 4'h0;
		end else if (fire) begin
			inDesc1_r <= sop;
			if (sop) begin
				dlo_r <= beat;
				fbe_r <= link.request_sideband_bus[`SB_FIRST_DWORD_BYTE_ENABLES +: 4];
				lbe_r <= link.request_sideband_bus[`SB_LAST_DWORD_BYTE_ENABLES +: 4];
				wr_r <= 4'h0;
			end else if (!inDesc1_r) begin
				wr_r <= wr_r + wrInc;
			end
		end
	end

	genvar k;
	generate
		for (k = 0; k < `PAY_DW_MAX; k++) begin : g_pay
			// Keep picks the lanes, so alignment mode needs no decode
			wire logic lo = kp[0] && (wr_r == 4'(k));
			wire logic hi = kp[1] && (wr_r + {3'h0, kp[0]} == 4'(k));
			always_ff @(posedge sys_clk or posedge sys_rst) begin
				if (sys_rst) begin
					pay_r[k] <= 32'h0;
				end else if (fire && !sop && !inDesc1_r && (lo || hi)) begin
					pay_r[k] <= lo ? beat[31:0] : beat[63:32];
				end
			end
			assign reqPayload[k*32 +: 32] = pay_r[k];
		end
	endgenerate

	// ----------------------------------------
	// Request and completion forming
	// ----------------------------------------
	// Descriptor-only packets end on the second descriptor beat
	logic [1:0] reqKind_r;
	logic [10:0] count_r;
	logic [7:0] tag_r;
	wire logic [10:0] pCount = inDesc1_r ? count : 11'h0;
	wire logic [1:0] kindNow = inDesc1_r ? lastKind : reqKind_r;
	// Payload packets end after the descriptor, so the tag is kept
	wire logic [7:0] tagNow = inDesc1_r ? beat[`DS_TAG-64 +: 8] : tag_r;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reqKind_r <= 2'h0;
			count_r <= 11'h0;
			tag_r <= 8'h00;
		end else if (fire && inDesc1_r) begin
			reqKind_r <= lastKind;
			count_r <= count;
			tag_r <= beat[`DS_TAG-64 +: 8];
		end
	end
	wire logic [10:0] cnt = inDesc1_r ? pCount : count_r;
	wire logic isAtom = (kindNow == completer_request_pkg::KIND_ATOMIC);
	wire logic isMem = (kindNow == completer_request_pkg::KIND_MEM_RD);
	wire logic isIoWr = (kindNow == completer_request_pkg::KIND_IO_WR);
	wire logic [12:0] fullBytes = {cnt, 2'h0};
	wire logic [12:0] spanBytes = (cnt == 11'h1) ? ((fbe_r == 4'h0) ? 13'h0001
		: 13'h4 - {11'h0, lowOff(fbe_r)} - {11'h0, highMiss(fbe_r)})
		: fullBytes - {11'h0, lowOff(fbe_r)} - {11'h0, highMiss(lbe_r)};
	wire logic [1:0] startOff = isAtom ? 2'h0 : lowOff(fbe_r);
	wire logic failed = (answerStatus != completer_request_pkg::STAT_SC);
	logic [61:0] dwAddr_r;
	wire logic [61:0] dwAddr = inDesc1_r ? dlo_r[`DS_ADDR +: 62] : dwAddr_r;
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			dwAddr_r <= 62'h0;
		end else if (fire && inDesc1_r) begin
			dwAddr_r <= dlo_r[`DS_ADDR +: 62];
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			reqStrobe <= 1'b0;
			reqKind <= 2'h0;
			reqByteAddr <= 64'h0;
			reqByteCount <= 13'h0;
			reqTag <= 8'h0;
			cplValid <= 1'b0;
			cplWithData <= 1'b0;
			cplDwords <= 11'h0;
			cplStatus <= 3'h0;
		end else begin
			reqStrobe <= done;
			cplValid <= done;
			if (done) begin
				reqKind <= kindNow;
				reqByteAddr <= {dwAddr, startOff};
				reqByteCount <= isAtom ? fullBytes : spanBytes;
				reqTag <= tagNow;
				// Single completion keeps split ordering trivially
				cplWithData <= !failed && !isIoWr;
				cplDwords <= (failed || isIoWr) ? 11'h0 : (isMem ? cnt : (isAtom ? cnt : 11'h1));
				cplStatus <= failed ? answerStatus : 3'(completer_request_pkg::STAT_SC);
			end
		end
	end
endmodule
`default_nettype wire

/* verification/completer_request_assertions.sv */
// Purpose: Stream rule checks on the request link
// Assumes: 64-bit path, descriptor in two beats
// Notes: Beat position rebuilt from the wire itself
`timescale 1ns/1ps
`default_nettype none
`include "completer_request_defines.svh"
module completer_request_assertions (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// Link
	input wire logic request_stream_valid,
	input wire logic request_stream_ready,
	input wire logic request_stream_last,
	input wire logic [`DATA_W-1:0] request_stream_data,
	input wire logic [`KEEP_W-1:0] request_stream_keep,
	input wire logic [`SIDE_W-1:0] request_sideband_bus
);
	// ----------------------------------------
	// Beat tracking
	// ----------------------------------------
	logic [2:0] beatCnt_r;
	logic [1:0] kind_r;
	logic [7:0] firstBe_r;
	wire logic beatFire = request_stream_valid && request_stream_ready;
	wire logic [7:0] laneMask = {{4{request_stream_keep[1]}}, {4{request_stream_keep[0]}}};
	wire logic [7:0] laneBytes = request_sideband_bus[15:8];
	// Enables ride the first beat, the count the second
	wire logic fbeFilled = firstBe_r[3:0] inside {4'hF, 4'hE, 4'hC, 4'h8};
	wire logic lbeFilled = firstBe_r[7:4] inside {4'hF, 4'h7, 4'h3, 4'h1};
	wire logic [10:0] descCount = request_stream_data[10:0];
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			beatCnt_r <= 3'h0;
			kind_r <= 2'h0;
			firstBe_r <= 8'h00;
		end else if (beatFire) begin
			beatCnt_r <= request_stream_last ? 3'h0 : beatCnt_r + 3'h1;
			// Kind sits in the upper descriptor beat
			if (beatCnt_r == 3'h1)
				kind_r <= request_stream_data[12:11];
			if (beatCnt_r == 3'h0)
				firstBe_r <= request_sideband_bus[7:0];
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	chk_valid_held: assert property (request_stream_valid && !request_stream_last |=> request_stream_valid)
		else $error("valid dropped inside a packet");
	chk_beat_stable: assert property (request_stream_valid && !request_stream_ready |=>
		request_stream_valid && $stable(request_stream_data) && $stable(request_sideband_bus)
		&& $stable(request_stream_last) && $stable(request_stream_keep))
		else $error("stalled beat changed");
	chk_sop_first: assert property (request_stream_valid |->
		request_sideband_bus[`SB_SOP] == (beatCnt_r == 3'h0))
		else $error("start flag on wrong beat");
	chk_desc_two_beats: assert property (request_stream_valid && beatCnt_r == 3'h0 |-> !request_stream_last)
		else $error("descriptor ended in one beat");
	chk_read_desc_only: assert property (request_stream_valid && beatCnt_r == 3'h1
		&& !request_stream_data[11] |-> request_stream_last)
		else $error("read packet longer than descriptor");
	chk_iowr_one_dword: assert property (request_stream_valid && beatCnt_r == 3'h2 && kind_r == 2'h1
		|-> request_stream_last && $onehot(request_stream_keep))
		else $error("io write payload not one dword");
	chk_lane_enables: assert property (request_stream_valid && beatCnt_r >= 3'h2
		|-> laneBytes != 8'h00 && (laneBytes & ~laneMask) == 8'h00)
		else $error("byte enables outside kept lanes");
	chk_atomic_lanes: assert property (request_stream_valid && beatCnt_r >= 3'h2 && kind_r == 2'h3
		|-> laneBytes == laneMask)
		else $error("atomic lane enables wrong");
	chk_payload_bound: assert property (request_stream_valid |-> beatCnt_r <= 3'h6)
		else $error("packet longer than eight dwords");
	chk_long_read_fill: assert property (request_stream_valid && beatCnt_r == 3'h1 && !request_stream_data[11]
		&& descCount > 11'h002 |-> fbeFilled && lbeFilled)
		else $error("long read enables not contiguous");
	cover property (beatFire && request_stream_last && beatCnt_r == 3'h1);
	cover property (request_stream_valid && !request_stream_ready ##1 beatFire);
	cover property (beatFire && request_stream_last && kind_r == 2'h3 && beatCnt_r >= 3'h5);
endmodule
`default_nettype wire

/* verification/tb.sv */
// Purpose: Self-checking bench for both link ends
// Assumes: Client answers one cycle after last beat
// Notes: Expected values worked out per request by hand
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ----------------------------------------
	// Stimulus and wiring
	// ----------------------------------------
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic reqValid = 1'b0;
	logic [1:0] reqKind = 2'h0;
	logic [63:0] reqAddr = 64'h0;
	logic [3:0] reqDwords = 4'h0;
	logic [3:0] reqFirstBe = 4'h0;
	logic [3:0] reqLastBe = 4'h0;
	logic [7:0] reqTag = 8'h00;
	logic [255:0] pattern = 256'hC0DE0007C0DE0006C0DE0005C0DE0004C0DE0003C0DE0002C0DE0001C0DE0000;
	logic addrAligned = 1'b0;
	logic userReady = 1'b1;
	logic stall = 1'b0;
	logic [2:0] answerStatus = 3'h0;
	logic reqReady, reqStrobe, cplValid, cplWithData;
	logic [1:0] seenKind;
	logic [63:0] seenAddr;
	logic [12:0] seenCount;
	logic [7:0] seenTag;
	logic [255:0] seenPayload;
	logic [10:0] cplDwords;
	logic [2:0] cplStatus;
	int mismatches = 0;
	int checks_done = 0;
	int cycles = 0;
	completer_request_if link();
	completer_request_device u_completer_request_device (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
		.reqValid(reqValid), .reqReady(reqReady), .reqKind(reqKind), .reqAddr(reqAddr),
		.reqDwords(reqDwords), .reqFirstBe(reqFirstBe), .reqLastBe(reqLastBe), .reqTag(reqTag),
		.reqPayload(pattern), .addrAligned(addrAligned));
	completer_request_client u_completer_request_client (.sys_clk(sys_clk), .sys_rst(sys_rst), .link(link),
		.userReady(userReady), .answerStatus(answerStatus), .reqStrobe(reqStrobe), .reqKind(seenKind),
		.reqByteAddr(seenAddr), .reqByteCount(seenCount), .reqTag(seenTag), .reqPayload(seenPayload),
		.cplValid(cplValid), .cplWithData(cplWithData), .cplDwords(cplDwords), .cplStatus(cplStatus));
	completer_request_assertions u_completer_request_assertions (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.request_stream_valid(link.request_stream_valid), .request_stream_ready(link.request_stream_ready),
		.request_stream_last(link.request_stream_last), .request_stream_data(link.request_stream_data),
		.request_stream_keep(link.request_stream_keep), .request_sideband_bus(link.request_sideband_bus));
	initial begin
		forever #50 sys_clk = ~sys_clk;
	end
	// Toggling ready while stall is set drops it every other cycle, stretching each beat after a fire
	always @(posedge sys_clk) begin
		userReady <= stall ? ~userReady : 1'b1;
		cycles++;
		if (cycles == 4000) begin
			mismatches++;
			$display("Error at %0t: run timed out", $time);
			final_report();
		end
	end
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic final_report();
		$display("Checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		checks_done++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// be packs last enables over first enables
	task automatic run(input logic [1:0] k, input logic [63:0] a, input logic [3:0] dw, input logic [7:0] be,
		input logic al, input logic [2:0] st, input logic [63:0] ea, input logic [12:0] ec, input logic [10:0] ed);
		logic [255:0] mask;
		logic [7:0] tg;
		logic wd;
		int n;
		n = (k == 2'h1) ? 1 : (k == 2'h3) ? int'(dw) : 0;
		mask = (n == 0) ? '0 : {256{1'b1}} >> (256 - 32 * n);
		wd = (st == 3'h0) && (k != 2'h1);
		tg = reqTag + 8'h01;
		@(posedge sys_clk);
		reqValid <= 1'b1;
		reqKind <= k;
		reqAddr <= a;
		reqDwords <= dw;
		reqFirstBe <= be[3:0];
		reqLastBe <= be[7:4];
		reqTag <= tg;
		addrAligned <= al;
		answerStatus <= st;
		do @(posedge sys_clk); while (reqReady !== 1'b1);
		reqValid <= 1'b0;
		do @(posedge sys_clk); while (reqStrobe !== 1'b1);
		check(256'(cplValid), 256'h1);
		check(256'(seenKind), 256'(k));
		check(256'(seenTag), 256'(tg));
		check(256'(seenAddr), 256'(ea));
		check(256'(seenCount), 256'(ec));
		check(seenPayload & mask, pattern & mask);
		check(256'(cplWithData), 256'(wd));
		check(256'(cplStatus), 256'(st));
		check(256'(cplDwords), 256'(ed));
	endtask
	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge sys_clk);
		sys_rst <= 1'b0;
		run(2'h0, 64'h1000, 4'h4, 8'hFF, 1'b0, 3'h0, 64'h1000, 13'h0010, 11'h004);
		run(2'h0, 64'h2000, 4'h1, 8'h06, 1'b0, 3'h0, 64'h2001, 13'h0002, 11'h001);
		run(2'h0, 64'h3000, 4'h3, 8'h5A, 1'b0, 3'h0, 64'h3001, 13'h000A, 11'h003);
		run(2'h0, 64'h4000, 4'h0, 8'h00, 1'b0, 3'h0, 64'h4000, 13'h0001, 11'h001);
		run(2'h1, 64'h5004, 4'h1, 8'h0F, 1'b1, 3'h0, 64'h5004, 13'h0004, 11'h000);
		run(2'h1, 64'h6000, 4'h1, 8'h0F, 1'b0, 3'h4, 64'h6000, 13'h0004, 11'h000);
		run(2'h2, 64'h0010, 4'h1, 8'h0C, 1'b0, 3'h0, 64'h0012, 13'h0002, 11'h001);
		run(2'h2, 64'h0020, 4'h1, 8'h0F, 1'b0, 3'h1, 64'h0020, 13'h0004, 11'h000);
		stall <= 1'b1;
		run(2'h3, 64'h7004, 4'h8, 8'h00, 1'b1, 3'h0, 64'h7004, 13'h0020, 11'h008);
		run(2'h3, 64'h8000, 4'h1, 8'h00, 1'b0, 3'h0, 64'h8000, 13'h0004, 11'h001);
		run(2'h3, 64'h8010, 4'h3, 8'h00, 1'b0, 3'h1, 64'h8010, 13'h000C, 11'h000);
		run(2'h0, 64'h9000, 4'h2, 8'h59, 1'b0, 3'h0, 64'h9000, 13'h0007, 11'h002);
		repeat (5) @(posedge sys_clk);
		final_report();
	end
endmodule
`default_nettype wire
